// File: hdl/cpb_bridge.sv
/*
 * Ordering core of a processor-to-PCI host bridge: address acceptance,
 * out-of-order read return with cache-to-cache intervention, PCI write
 * combining and the serial interrupt stream.
 * Assumes processor, memory and PCI ports are logic on clock_i; the
 * interrupt sources are asynchronous pins.
 */
// Contract
// - Read data returns in availability order
// - Fast memory read may pass slow PCI read
// - Accept one address every two clocks
// - Holder supplies modified data directly to requester
// - Merge eligible memory writes into one transaction
// - Merge only ascending, consecutive, non-overlapping addresses
// - Barrier or sync between writes prevents merging
// - Processor side is 64-bit pipelined bus
// - PCI side is 64-bit bus
// - Interrupts leave as a serial stream
module cpb_bridge import cpb_pkg::*; (
   input wire logic clock_i,
   input wire logic rst_i,
   input wire logic cpu_addr_valid_i,
   input wire logic [CPB_ADDR_W-1:0] cpu_addr_i,
   input wire logic [CPB_TAG_W-1:0] cpu_tag_i,
   input wire logic [2:0] cpu_kind_i,
   input wire logic [CPB_DATA_W-1:0] cpu_wdata_i,
   input wire logic [CPB_BE_W-1:0] cpu_wbe_i,
   output logic cpu_addr_ready_o,
   output logic rd_req_valid_o,
   output logic rd_req_pci_o,
   output logic [CPB_ADDR_W-1:0] rd_req_addr_o,
   output logic [CPB_TAG_W-1:0] rd_req_tag_o,
   input wire logic [CPB_NSRC-1:0] src_valid_i,
   input wire logic [CPB_NSRC*CPB_TAG_W-1:0] src_tag_i,
   input wire logic [CPB_NSRC*CPB_DATA_W-1:0] src_data_i,
   output logic [CPB_NSRC-1:0] src_ready_o,
   output logic cpu_dvalid_o,
   output logic [CPB_TAG_W-1:0] cpu_dtag_o,
   output logic [CPB_DATA_W-1:0] cpu_data_o,
   input wire logic pci_wready_i,
   output logic pci_wvalid_o,
   output logic pci_wstart_o,
   output logic pci_wmwi_o,
   output logic [CPB_ADDR_W-1:0] pci_waddr_o,
   output logic [CPB_DATA_W-1:0] pci_wdata_o,
   output logic [CPB_BE_W-1:0] pci_wbe_o,
   input wire logic [CPB_NIRQ-1:0] irq_src_i,
   output logic irq_ser_o,
   output logic irq_frame_o
);
   logic ready_q;
   logic accept;
   logic is_write;
   logic is_barrier;
   logic contig;
   cpb_wc_e wc_q;
   logic [CPB_ADDR_W-1:0] next_addr_q;
   logic mwi_q;
   logic [CPB_NSRC-1:0] full_q;
   logic [CPB_TAG_W-1:0] hold_tag_q [CPB_NSRC];
   logic [CPB_DATA_W-1:0] hold_data_q [CPB_NSRC];
   logic [CPB_NSRC-1:0] grant;
   logic [CPB_NIRQ-1:0] irq_meta_q;
   logic [CPB_NIRQ-1:0] irq_sync_q;
   logic [CPB_NIRQ-1:0] irq_snap_q;
   logic [2:0] irq_cnt_q;

   // All checks below run on the core clock and sleep through reset
   default clocking chk_cb @(posedge clock_i);
   endclocking
   default disable iff (rst_i);

   assign accept = cpu_addr_valid_i && ready_q;
   assign is_write = (cpu_kind_i == CPB_K_PCI_MW) ||
                     (cpu_kind_i == CPB_K_PCI_MWI);
   assign is_barrier = (cpu_kind_i == CPB_K_IO_BARRIER) ||
                       (cpu_kind_i == CPB_K_SYNC);
   // Overlap or descent breaks the chain just as a gap does
   assign contig = (wc_q == CPB_WC_OPEN) && (cpu_addr_i == next_addr_q) &&
                   ((cpu_kind_i == CPB_K_PCI_MWI) == mwi_q);

   // Address window drops for one clock after each tenure, giving the
   // streamed two-clock rate; a stalled PCI side also closes it
   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         ready_q <= CPB_READY_RST;
      end else begin
         ready_q <= !accept && pci_wready_i;
      end
   end
   assign cpu_addr_ready_o = ready_q;

   // Reads are forwarded straight on, tagged, to memory or PCI
   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         rd_req_valid_o <= 1'b0;
         rd_req_pci_o <= 1'b0;
         rd_req_addr_o <= '0;
         rd_req_tag_o <= '0;
      end else begin
         rd_req_valid_o <= accept && (cpu_kind_i == CPB_K_MEM_RD ||
                                      cpu_kind_i == CPB_K_PCI_RD);
         rd_req_pci_o <= cpu_kind_i == CPB_K_PCI_RD;
         rd_req_addr_o <= cpu_addr_i;
         rd_req_tag_o <= cpu_tag_i;
      end
   end

   // Write-combining burst tracker; barriers always close the burst
   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         wc_q <= CPB_WC_IDLE;
         next_addr_q <= '0;
         mwi_q <= 1'b0;
      end else if (accept && is_write) begin
         wc_q <= CPB_WC_OPEN;
         next_addr_q <= cpu_addr_i + CPB_BEAT_BYTES;
         mwi_q <= cpu_kind_i == CPB_K_PCI_MWI;
      end else if (accept && is_barrier) begin
         wc_q <= CPB_WC_IDLE;
      end
   end

   // Each write leaves as one beat, unchanged; start marks a new
   // transaction, so merged beats simply lack it
   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         pci_wvalid_o <= 1'b0;
         pci_wstart_o <= 1'b0;
         pci_wmwi_o <= 1'b0;
         pci_waddr_o <= '0;
         pci_wdata_o <= '0;
         pci_wbe_o <= '0;
      end else begin
         pci_wvalid_o <= accept && is_write;
         pci_wstart_o <= accept && is_write && !contig;
         pci_wmwi_o <= cpu_kind_i == CPB_K_PCI_MWI;
         pci_waddr_o <= cpu_addr_i;
         pci_wdata_o <= cpu_wdata_i;
         pci_wbe_o <= cpu_wbe_i;
      end
   end

   // Fixed priority over held returns: intervention, memory, then PCI.
   // Whichever is ready goes, regardless of issue order
   always_comb begin
      grant = '0;
      for (int i = 0; i < CPB_NSRC; i++) begin
         if (full_q[i] && grant == '0) begin
            grant[i] = 1'b1;
         end
      end
   end

   // One holding slot per source; a source waits while its slot is full
   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         full_q <= '0;
         for (int i = 0; i < CPB_NSRC; i++) begin
            hold_tag_q[i] <= '0;
            hold_data_q[i] <= '0;
         end
      end else begin
         for (int i = 0; i < CPB_NSRC; i++) begin
            if (src_valid_i[i] && !full_q[i]) begin
               full_q[i] <= 1'b1;
               hold_tag_q[i] <= src_tag_i[i*CPB_TAG_W +: CPB_TAG_W];
               hold_data_q[i] <= src_data_i[i*CPB_DATA_W +: CPB_DATA_W];
            end else if (grant[i]) begin
               full_q[i] <= 1'b0;
            end
         end
      end
   end
   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         src_ready_o <= '0;
      end else begin
         src_ready_o <= ~(full_q & ~grant) & ~(src_valid_i & ~full_q);
      end
   end

   // Returned data to the processor; intervention data goes straight
   // to the requester with no memory write-back
   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         cpu_dvalid_o <= 1'b0;
         cpu_dtag_o <= '0;
         cpu_data_o <= '0;
      end else begin
         cpu_dvalid_o <= grant != '0;
         cpu_dtag_o <= '0;
         cpu_data_o <= '0;
         for (int i = 0; i < CPB_NSRC; i++) begin
            if (grant[i]) begin
               cpu_dtag_o <= hold_tag_q[i];
               cpu_data_o <= hold_data_q[i];
            end
         end
      end
   end

   // Interrupt pins pass two flops, then a snapshot per frame so one
   // frame never mixes two sampling instants
   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         irq_meta_q <= '0;
         irq_sync_q <= '0;
      end else begin
         irq_meta_q <= irq_src_i;
         irq_sync_q <= irq_meta_q;
      end
   end
   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         irq_cnt_q <= CPB_IRQ_CNT_RST;
         irq_snap_q <= '0;
         irq_ser_o <= 1'b0;
         irq_frame_o <= 1'b0;
      end else begin
         irq_cnt_q <= irq_cnt_q + 3'h1;
         if (irq_cnt_q == CPB_IRQ_LAST) begin
            irq_snap_q <= irq_sync_q;
         end
         irq_ser_o <= irq_snap_q[irq_cnt_q];
         irq_frame_o <= irq_cnt_q == CPB_IRQ_CNT_RST;
      end
   end

   // Checks
   addr_gap_a: assert property (accept |=> !cpu_addr_ready_o)
      else $error("Address accepted in back-to-back clocks");
   addr_reopen_a: assert property (
      accept ##1 pci_wready_i |=> cpu_addr_ready_o)
      else $error("Address window did not reopen after two clocks");
   // Held against the chain end as it stood before this beat moved it
   merge_chain_a: assert property (
      pci_wvalid_o && !pci_wstart_o |->
      pci_waddr_o == $past(next_addr_q) && pci_wmwi_o == $past(mwi_q))
      else $error("Merged beat not contiguous");
   barrier_split_a: assert property (
      accept && is_barrier |=> wc_q == CPB_WC_IDLE)
      else $error("Barrier left a write burst open");
   beat_copy_a: assert property (
      accept && is_write |=> pci_wvalid_o &&
      pci_wdata_o == $past(cpu_wdata_i) && pci_wbe_o == $past(cpu_wbe_i))
      else $error("Write beat altered");
   new_burst_a: assert property (
      accept && is_write && wc_q == CPB_WC_IDLE |=> pci_wstart_o)
      else $error("Burst began without start");
   return_prio_a: assert property (
      full_q[CPB_SRC_MEM] && !full_q[CPB_SRC_IVN] |=> cpu_dvalid_o &&
      cpu_dtag_o == $past(hold_tag_q[CPB_SRC_MEM]))
      else $error("Ready memory data was held back");
   ivn_first_a: assert property (
      full_q[CPB_SRC_IVN] |=> cpu_dvalid_o &&
      cpu_data_o == $past(hold_data_q[CPB_SRC_IVN]))
      else $error("Intervention data not forwarded");
   ready_drain_a: assert property (
      full_q != '0 |-> ##[1:3] cpu_dvalid_o)
      else $error("Held read data not returned");
   irq_frame_a: assert property (
      irq_frame_o |=> !irq_frame_o [*7] ##1 irq_frame_o)
      else $error("Interrupt frame length wrong");
   merge_cov: cover property (
      pci_wvalid_o && pci_wstart_o ##2 pci_wvalid_o && !pci_wstart_o);
   pass_cov: cover property (
      rd_req_valid_o && rd_req_pci_o ##[1:20] grant[CPB_SRC_MEM]);
   ivn_cov: cover property (grant[CPB_SRC_IVN]);
   stream_cov: cover property (accept ##2 accept ##2 accept);
endmodule // cpb_bridge

// File: pkg/cpb_pkg.sv
/*
 * Constants shared by the processor-to-PCI bridge ordering block:
 * bus widths, transaction kinds, read-return sources and the serial
 * interrupt frame.
 * Assumes a single 100 MHz core clock and a synchronous reset.
 */
package cpb_pkg;
   // Processor bus and PCI bus are both 64 bits wide
   localparam int CPB_DATA_W = 64;
   localparam int CPB_BE_W = 8;
   localparam int CPB_ADDR_W = 32;
   localparam int CPB_TAG_W = 4;
   localparam int CPB_CPU_MHZ = 167;
   localparam int CPB_PCI_MHZ = 66;
   // Bytes covered by one beat; a contiguous write starts here next
   localparam logic [CPB_ADDR_W-1:0] CPB_BEAT_BYTES = 32'h0000_0008;

   // Address-tenure spacing, in clocks
   localparam int CPB_ADDR_GAP = 2;
   localparam int CPB_OLD_ADDR_GAP = 3;

   // Transaction kinds presented with each address tenure
   typedef enum logic [2:0] {
      CPB_K_MEM_RD = 3'h0,
      CPB_K_PCI_RD = 3'h1,
      CPB_K_PCI_MW = 3'h2,
      CPB_K_PCI_MWI = 3'h3,
      CPB_K_IO_BARRIER = 3'h4,
      CPB_K_SYNC = 3'h5
   } cpb_kind_e;

   // Read-return sources, highest priority first
   localparam int CPB_NSRC = 3;
   localparam int CPB_SRC_IVN = 0;
   localparam int CPB_SRC_MEM = 1;
   localparam int CPB_SRC_PCI = 2;

   // Serial interrupt frame
   localparam int CPB_NIRQ = 8;
   localparam logic [2:0] CPB_IRQ_LAST = 3'h7;

   // Reset values
   localparam logic CPB_READY_RST = 1'b0;
   localparam logic [2:0] CPB_IRQ_CNT_RST = 3'h0;

   // Write-combining state: idle or an open PCI burst
   typedef enum logic [0:0] {
      CPB_WC_IDLE = 1'b0,
      CPB_WC_OPEN = 1'b1
   } cpb_wc_e;
endpackage

// File: dv/cpb_src_model.sv
/* Return-source model: memory, remote cache and PCI answer reads.
   Assumes cpb_pkg and a bench that drives at the falling edge. */
module cpb_src_model import cpb_pkg::*; (
   input wire logic clock_i,
   input wire logic req_i,
   input wire logic req_pci_i,
   input wire logic [CPB_ADDR_W-1:0] req_addr_i,
   input wire logic [CPB_TAG_W-1:0] req_tag_i,
   input wire logic ivn_i,
   input wire logic [CPB_TAG_W-1:0] ivn_tag_i,
   input wire logic [CPB_DATA_W-1:0] ivn_data_i,
   input wire logic [CPB_NSRC-1:0] ready_i,
   output logic [CPB_NSRC-1:0] valid_o,
   output logic [CPB_NSRC*CPB_TAG_W-1:0] tag_o,
   output logic [CPB_NSRC*CPB_DATA_W-1:0] data_o
);
   timeunit 1ns;
   timeprecision 1ps;
   localparam int tw = CPB_TAG_W;
   localparam int dw = CPB_DATA_W;
   typedef struct {int due; logic [67:0] td;} cpb_ret_s;
   cpb_ret_s q[CPB_NSRC][$];
   cpb_ret_s r;
   int cyc = 0;

   // Memory answers in 2 cycles, PCI in 12, so reads may pass
   always @(posedge clock_i) begin
      cyc++;
      if (req_i === 1'b1) begin
         r.td = {req_tag_i, req_addr_i, ~req_addr_i};
         r.due = cyc + (req_pci_i ? 12 : 2);
         q[req_pci_i ? CPB_SRC_PCI : CPB_SRC_MEM].push_back(r);
      end
      // Holder hands its modified line over, nothing goes to memory
      if (ivn_i === 1'b1) begin
         r.td = {ivn_tag_i, ivn_data_i};
         r.due = cyc;
         q[CPB_SRC_IVN].push_back(r);
      end
   end

   initial begin
      valid_o = '0;
      tag_o = '0;
      data_o = '0;
   end

   // One beat per two clocks into a free slot; idle lines toggle so a
   // stale value is never mistaken for data
   always @(negedge clock_i) begin
      for (int s = 0; s < CPB_NSRC; s++) begin
         if (valid_o[s] || ready_i[s] !== 1'b1 || q[s].size() == 0 ||
             q[s][0].due > cyc) begin
            valid_o[s] = 1'b0;
            tag_o[s*tw+:tw] = ~tag_o[s*tw+:tw];
            data_o[s*dw+:dw] = ~data_o[s*dw+:dw];
         end else begin
            r = q[s].pop_front();
            valid_o[s] = 1'b1;
            {tag_o[s*tw+:tw], data_o[s*dw+:dw]} = r.td;
         end
      end
   end
endmodule // cpb_src_model

// File: dv/cpb_bridge_tb.sv
/* Self-checking bench for the bridge ordering core: write combining,
   read return order, address rate and interrupt frames.
   Assumes cpb_pkg and the return-source model cpb_src_model. */
module cpb_bridge_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import cpb_pkg::*;
   logic clock_i = 1'b0, rst_i = 1'b1, cpu_addr_valid_i = 1'b0;
   logic [CPB_ADDR_W-1:0] cpu_addr_i = '0, rd_req_addr_o, pci_waddr_o;
   logic [CPB_TAG_W-1:0] cpu_tag_i = '0, rd_req_tag_o, cpu_dtag_o;
   logic [2:0] cpu_kind_i = '0;
   logic [CPB_DATA_W-1:0] cpu_wdata_i = '0, cpu_data_o, pci_wdata_o;
   logic [CPB_BE_W-1:0] cpu_wbe_i = '0, pci_wbe_o;
   logic cpu_addr_ready_o, rd_req_valid_o, rd_req_pci_o, cpu_dvalid_o;
   logic [CPB_NSRC-1:0] src_valid_i, src_ready_o;
   logic [CPB_NSRC*CPB_TAG_W-1:0] src_tag_i;
   logic [CPB_NSRC*CPB_DATA_W-1:0] src_data_i;
   logic pci_wready_i = 1'b1, pci_wvalid_o, pci_wstart_o, pci_wmwi_o;
   logic [CPB_NIRQ-1:0] irq_src_i = '0;
   logic irq_ser_o, irq_frame_o, ivn = 1'b0, w_open = 1'b0, w_mwi;
   logic [CPB_TAG_W-1:0] ivn_tag = '0;
   logic [CPB_DATA_W-1:0] ivn_data = '0;
   logic [CPB_ADDR_W-1:0] w_last;
   logic [67:0] rq[$];
   logic [105:0] wq[$];
   int n_fail = 0, n_compared = 0;
   // Directed burst pattern: kinds and offsets, one pair per tenure
   logic [2:0] ks[15] = '{2, 2, 0, 2, 2, 2, 2, 3, 3, 5, 3, 4, 3, 2, 2};
   int os[15] = '{0, 8, 16, 16, 24, 16, 16, 24, 32, 0, 40, 0, 48, 56, 72};

   cpb_bridge cpb_bridge_inst (
      .clock_i, .rst_i, .cpu_addr_valid_i, .cpu_addr_i, .cpu_tag_i,
      .cpu_kind_i, .cpu_wdata_i, .cpu_wbe_i, .cpu_addr_ready_o,
      .rd_req_valid_o, .rd_req_pci_o, .rd_req_addr_o, .rd_req_tag_o,
      .src_valid_i, .src_tag_i, .src_data_i, .src_ready_o, .cpu_dvalid_o,
      .cpu_dtag_o, .cpu_data_o, .pci_wready_i, .pci_wvalid_o,
      .pci_wstart_o, .pci_wmwi_o, .pci_waddr_o, .pci_wdata_o, .pci_wbe_o,
      .irq_src_i, .irq_ser_o, .irq_frame_o);
   cpb_src_model cpb_src_model_inst (
      .clock_i, .req_i(rd_req_valid_o), .req_pci_i(rd_req_pci_o),
      .req_addr_i(rd_req_addr_o), .req_tag_i(rd_req_tag_o), .ivn_i(ivn),
      .ivn_tag_i(ivn_tag), .ivn_data_i(ivn_data), .ready_i(src_ready_o),
      .valid_o(src_valid_i), .tag_o(src_tag_i), .data_o(src_data_i));

   always #5 clock_i = ~clock_i;

   task automatic check(string what, logic [127:0] seen, exp);
      n_compared++;
      if (seen !== exp) begin
         n_fail++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic stop_test();
      $display("Compared %0d, mismatches %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   // One tenure, held until taken; notes the beat or memory read it causes.
   // Merge only on same command, exactly +8, no barrier since
   task automatic tenure(logic [2:0] k, logic [31:0] a, int n_exp);
      int n;
      logic [CPB_DATA_W-1:0] d;
      logic [CPB_BE_W-1:0] b;
      n = 0;
      d = {$urandom, $urandom};
      b = CPB_BE_W'($urandom);
      cpu_addr_valid_i = 1'b1;
      cpu_kind_i = k;
      cpu_addr_i = a;
      cpu_tag_i = a[6:3];
      cpu_wdata_i = d;
      cpu_wbe_i = b;
      while (cpu_addr_ready_o !== 1'b1) begin
         if (n == 30) begin
            check("addr_taken", 0, 1);
            stop_test();
         end
         n++;
         @(negedge clock_i);
      end
      if (n_exp >= 0) check("addr_rate", n, n_exp);
      @(posedge clock_i);
      if (k == CPB_K_PCI_MW || k == CPB_K_PCI_MWI) begin
         wq.push_back({!(w_open && w_mwi == k[0] &&
            a == w_last + CPB_BEAT_BYTES), k[0], a, d, b});
         w_open = 1'b1;
         w_mwi = k[0];
         w_last = a;
      end else if (k == CPB_K_IO_BARRIER || k == CPB_K_SYNC) begin
         w_open = 1'b0;
      end else if (k == CPB_K_MEM_RD) begin
         rq.push_back({a[6:3], a, ~a});
      end
      @(negedge clock_i);
   endtask

   // Each write beat or read return takes the oldest note of its kind
   always @(negedge clock_i) begin
      logic [105:0] e, s;
      if (rst_i === 1'b0 && pci_wvalid_o === 1'b1) begin
         e = wq.size() ? wq.pop_front() : '1;
         s = {pci_wstart_o, pci_wmwi_o, pci_waddr_o, pci_wdata_o, pci_wbe_o};
         check("wctl", s[105:72], e[105:72]);
         check("wbeat", s[71:0], e[71:0]);
      end
      if (rst_i === 1'b0 && cpu_dvalid_o === 1'b1) begin
         e = rq.size() ? rq.pop_front() : '1;
         s = {cpu_dtag_o, cpu_data_o};
         check("read", s, e);
      end
   end

   initial begin
      logic [31:0] a;
      logic [7:0] v, got;
      logic [2:0] k;
      int n, o;
      a = $urandom(32'he4f55e6f);
      repeat (6) @(negedge clock_i);
      rst_i = 1'b0;
      repeat (2) @(negedge clock_i);
      a = $urandom & 32'hffff_f000;
      // Bursts broken by overlap, command change, gap and barriers
      for (int i = 0; i < 15; i++) tenure(ks[i], a + os[i], i ? 1 : -1);
      // Slow PCI read issued first must come back after the memory read
      tenure(CPB_K_PCI_RD, a + 32'h8, 1);
      tenure(CPB_K_MEM_RD, a + 32'h18, 1);
      rq.push_back({4'h1, a + 32'h8, ~(a + 32'h8)});
      cpu_addr_valid_i = 1'b0;
      repeat (20) @(negedge clock_i);
      // Cache-to-cache line with no tenure of its own
      ivn_tag = 4'h5;
      ivn_data = {$urandom, $urandom};
      rq.push_back({ivn_tag, ivn_data});
      ivn = 1'b1;
      @(negedge clock_i);
      ivn = 1'b0;
      // Downstream stall refuses new tenures
      pci_wready_i = 1'b0;
      repeat (3) @(negedge clock_i);
      check("stall_ready", cpu_addr_ready_o, 0);
      pci_wready_i = 1'b1;
      // Random mix of writes, reads and barriers
      o = 256;
      for (int i = 0; i < 40; i++) begin
         k = 3'($urandom_range(5));
         o = o + 8 * $urandom_range(2);
         tenure(k == 3'h1 ? 3'h2 : k, a + o, i ? 1 : -1);
      end
      cpu_addr_valid_i = 1'b0;
      // Interrupt levels come out bit k in frame cycle k
      for (int j = 0; j < 4; j++) begin
         v = 8'($urandom);
         irq_src_i = v;
         repeat (20) @(negedge clock_i);
         n = 0;
         while (irq_frame_o !== 1'b1 && n < 10) begin
            n++;
            @(negedge clock_i);
         end
         if (irq_frame_o !== 1'b1) begin
            check("irq_start", irq_frame_o, 1);
            stop_test();
         end
         for (int b = 0; b < 8; b++) begin
            got[b] = irq_ser_o;
            @(negedge clock_i);
         end
         check("irq_frame", got, v);
      end
      n = 0;
      while ((wq.size() + rq.size()) > 0 && n < 200) begin
         n++;
         @(negedge clock_i);
      end
      check("notes_left", wq.size() + rq.size(), 0);
      stop_test();
   end
endmodule // cpb_bridge_tb
